// file: host_port_pkg.sv
// package: shared types and constants of the parallel host port pin block
package host_port_pkg;

    // ********************************************************************
    // register selection codes
    // ********************************************************************
    typedef enum logic [1:0] {
        sel_control = 2'b00,
        sel_data_inc = 2'b01,
        sel_address = 2'b10,
        sel_data = 2'b11
    } reg_sel_t;

    // ********************************************************************
    // widths and reset values
    // ********************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned MEM_DEPTH = 16;
    localparam int unsigned MEM_AW = 4;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] ADDRESS_RESET = 16'h0000;
    localparam logic [7:0] DATA_LINES_RESET = 8'h00;
    // byte order: first byte carries the high half of a word
    localparam int unsigned FIRST_BYTE_LSB = 8;
    localparam int unsigned SECOND_BYTE_LSB = 0;
    // ready stays low this many nanoseconds after each completed data strobe
    localparam int unsigned BUSY_NS = 100;
    localparam int unsigned CLK_NS = 50;
    localparam logic [1:0] BUSY_CYCLES = 2'((BUSY_NS + CLK_NS - 1) / CLK_NS);

    // host strobe bundle, sampled synchronously
    typedef struct packed {
        logic       port_select_n;
        logic       data_strobe_n;
        logic       address_strobe_n;
        logic       read_not_write;
        logic       byte_identify;
        logic [1:0] reg_select;
    } host_ctl_t;

    // word bus to the memory
    typedef struct packed {
        logic                write;
        logic [MEM_AW-1:0]   addr;
        logic [WORD_W-1:0]   wdata;
    } mem_req_t;

endpackage : host_port_pkg

// file: host_port_mem.sv
// small word memory reached through the host port, registered read data
`timescale 1ns/100ps
`default_nettype none
module host_port_mem
    import host_port_pkg::*;
(
    // clock
    input  wire logic                clk_i,
    // access
    input  wire mem_req_t            req_i,
    output var  logic [WORD_W-1:0]   rdata_o
);

    logic [WORD_W-1:0] store [MEM_DEPTH];

    // write, then read data from a register; no reset on the array
    always_ff @(posedge clk_i) begin
        if (req_i.write) begin
            store[req_i.addr] <= req_i.wdata;
        end
        rdata_o <= store[req_i.addr];
    end

endmodule : host_port_mem
`default_nettype wire

// file: host_port_pin_interface.sv
// top: parallel host port pin logic with keepers, straps and byte assembly
// Summary of operation
// R1: release data lines unless reading with output-off high; code also drives them as GPIO when gpio_mode_i is high and unselected
// R2: enabled keepers hold last line level
// R3: keepers off at reset, software bit toggles
// R4: data lines usable as general-purpose I/O
// R5: decode register select to one register
// R6: wide strap high ignores register select
// R7: byte identify picks first or second byte
// R8: wide strap high ignores byte identify
// R9: host holds select low whole access
// R10: register-select pull-ups only when strap sampled low
// R11: read_not_write high reads, low writes
// R12: address strobe loads the address pointer
// R13: ready output tells host next transfer ok
// R14: sample enable strap at reset release only
// R15: strap low ignores strobes, never drives lines; code still drives them as GPIO when gpio_mode_i is high
`timescale 1ns/100ps
`default_nettype none
module host_port_pin_interface
    import host_port_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // straps and global output control
    input  wire logic                port_enable_strap_i,
    input  wire logic                wide_mode_strap_i,
    input  wire logic                output_off_n_i,
    // host control inputs
    input  wire host_ctl_t           host_ctl_i,
    input  wire logic [WORD_W-1:0]   wide_data_i,
    // host data lines, three-signal form
    input  wire logic [DATA_W-1:0]   host_data_lines_i,
    output var  logic [DATA_W-1:0]   host_data_lines_o,
    output var  logic [DATA_W-1:0]   host_data_lines_oe_n_o,
    output var  logic [DATA_W-1:0]   data_keeper_level_o,
    output var  logic                data_keeper_active_o,
    // host status and pull-up control
    output var  logic                port_ready_o,
    output var  logic                reg_select_pullup_o,
    output var  logic [WORD_W-1:0]   wide_data_o,
    output var  logic                wide_data_oe_n_o,
    // processor side: bank switch keeper bit and general-purpose I/O
    input  wire logic                data_keeper_enable_i,
    input  wire logic                gpio_mode_i,
    input  wire logic [DATA_W-1:0]   gpio_out_i,
    input  wire logic [DATA_W-1:0]   gpio_dir_i,
    output var  logic [DATA_W-1:0]   gpio_in_o,
    output var  logic [ADDR_W-1:0]   address_pointer_reg_o,
    output var  logic [WORD_W-1:0]   control_reg_o
);

    // ********************************************************************
    // strap capture and strobe qualification
    // ********************************************************************
    logic              strap_pending;
    logic              port_on;
    logic              wide_mode;
    logic              strobe_prev;
    logic              astrobe_prev;
    logic              strobe_end;
    logic              astrobe_end;
    logic              selected;
    logic [1:0]        busy_count;
    logic [WORD_W-1:0] read_word;
    logic [WORD_W-1:0] write_hold;
    logic [7:0]        next_byte;
    reg_sel_t          sel;
    mem_req_t          mem_req;
    logic [WORD_W-1:0] mem_rdata;
    logic              reading;

    // strap is taken on the first edge after release, never under reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_pending <= 1'b1;
            port_on       <= 1'b0;
            wide_mode     <= 1'b0;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            port_on       <= port_enable_strap_i; // R14
            wide_mode     <= wide_mode_strap_i;
        end
    end

    // strobes only count while select is low and the port is on
    assign selected = port_on & ~host_ctl_i.port_select_n; // R9 R15

    // wide mode forces the data register; narrow mode decodes the pins
    assign sel = wide_mode ? sel_data : reg_sel_t'(host_ctl_i.reg_select); // R5 R6

    // detect end (rising edge) of data and address strobes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_prev  <= 1'b1;
            astrobe_prev <= 1'b1;
        end else begin
            strobe_prev  <= host_ctl_i.data_strobe_n | ~selected;
            astrobe_prev <= host_ctl_i.address_strobe_n | ~selected;
        end
    end
    assign strobe_end  = ~strobe_prev & (host_ctl_i.data_strobe_n | ~selected);
    assign astrobe_end = ~astrobe_prev & (host_ctl_i.address_strobe_n | ~selected);

    // ********************************************************************
    // host registers
    // ********************************************************************
    // second byte completes a word; wide mode always moves a whole word
    assign next_byte = host_data_lines_i;

    // control register and staged write half
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_reg_o <= CONTROL_RESET;
            write_hold    <= CONTROL_RESET;
        end else if (strobe_end && !host_ctl_i.read_not_write) begin // R11
            if (wide_mode) begin
                write_hold <= wide_data_i; // R8
            end else if (!host_ctl_i.byte_identify) begin
                write_hold[FIRST_BYTE_LSB +: 8] <= next_byte; // R7
            end else begin
                write_hold[SECOND_BYTE_LSB +: 8] <= next_byte; // R7
            end
            if (sel == sel_control && (wide_mode || host_ctl_i.byte_identify)) begin
                control_reg_o <= {write_hold[FIRST_BYTE_LSB +: 8], next_byte}; // R5
            end
        end
    end

    // address pointer: loaded by address strobe or a select-coded write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            address_pointer_reg_o <= ADDRESS_RESET;
        end else if (astrobe_end) begin
            address_pointer_reg_o <= {address_pointer_reg_o[7:0], host_data_lines_i}; // R12
        end else if (strobe_end && sel == sel_address && !host_ctl_i.read_not_write
                     && !wide_mode && host_ctl_i.byte_identify) begin
            address_pointer_reg_o <= {write_hold[FIRST_BYTE_LSB +: 8], next_byte}; // R5
        end else if (strobe_end && sel == sel_data_inc
                     && (wide_mode || host_ctl_i.byte_identify)) begin
            address_pointer_reg_o <= address_pointer_reg_o + 16'h0001;
        end
    end

    // word memory behind the data registers
    always_comb begin
        mem_req.addr  = address_pointer_reg_o[MEM_AW-1:0];
        mem_req.wdata = wide_mode ? wide_data_i : {write_hold[FIRST_BYTE_LSB +: 8], next_byte};
        mem_req.write = strobe_end && !host_ctl_i.read_not_write
                        && (sel == sel_data || sel == sel_data_inc)
                        && (wide_mode || host_ctl_i.byte_identify);
    end

    host_port_mem u_mem (
        .clk_i   (clk_i),
        .req_i   (mem_req),
        .rdata_o (mem_rdata)
    );

    // read word selection
    always_comb begin
        unique case (sel)
            sel_control:  read_word = control_reg_o;
            sel_address:  read_word = address_pointer_reg_o;
            sel_data_inc: read_word = mem_rdata;
            sel_data:     read_word = mem_rdata;
        endcase
    end

    // ********************************************************************
    // pin drivers, keepers, ready
    // ********************************************************************
    assign reading = selected & ~host_ctl_i.data_strobe_n & host_ctl_i.read_not_write;

    // with output-off high, drive during a read strobe or as GPIO when unselected; else release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_data_lines_o      <= DATA_LINES_RESET;
            host_data_lines_oe_n_o <= '1;
            wide_data_o            <= '0;
            wide_data_oe_n_o       <= 1'b1;
        end else begin
            wide_data_o      <= read_word;
            wide_data_oe_n_o <= ~(reading & wide_mode & output_off_n_i); // R1
            if (!output_off_n_i) begin
                host_data_lines_oe_n_o <= '1; // R1
            end else if (reading && !wide_mode) begin
                host_data_lines_oe_n_o <= '0; // R1
                host_data_lines_o <= host_ctl_i.byte_identify ?
                    read_word[SECOND_BYTE_LSB +: 8] : read_word[FIRST_BYTE_LSB +: 8]; // R7
            end else if (gpio_mode_i && !selected) begin
                host_data_lines_oe_n_o <= ~gpio_dir_i; // R4
                host_data_lines_o      <= gpio_out_i;  // R4
            end else begin
                host_data_lines_oe_n_o <= '1; // R1 R15
            end
        end
    end

    // keepers: off at reset, then follow the bank switch bit; latch level
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_keeper_active_o <= 1'b0; // R3
            data_keeper_level_o  <= DATA_LINES_RESET;
            gpio_in_o            <= DATA_LINES_RESET;
        end else begin
            data_keeper_active_o <= data_keeper_enable_i; // R3
            data_keeper_level_o  <= host_data_lines_i;    // R2
            gpio_in_o            <= host_data_lines_i;    // R4
        end
    end

    // ready drops for a fixed busy time after each data strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_count          <= 2'b00;
            port_ready_o        <= 1'b0;
            reg_select_pullup_o <= 1'b0;
        end else begin
            reg_select_pullup_o <= ~strap_pending & ~port_on; // R10
            if (strobe_end) begin
                busy_count <= BUSY_CYCLES;
            end else if (busy_count != 2'b00) begin
                busy_count <= busy_count - 2'b01;
            end
            port_ready_o <= port_on && !strobe_end && busy_count <= 2'b01; // R13
        end
    end

endmodule : host_port_pin_interface
`default_nettype wire

// file: host_port_chk.sv
// checker: pin timing assertions for the host port block
`timescale 1ns/100ps
`default_nettype none
module host_port_chk
    import host_port_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // watched inputs
    input  wire logic                output_off_n_i,
    input  wire host_ctl_t           host_ctl_i,
    input  wire logic                data_keeper_enable_i,
    input  wire logic                gpio_mode_i,
    input  wire logic                wide_mode_strap_i,
    // watched outputs
    input  wire logic [DATA_W-1:0]   host_data_lines_oe_n_o,
    input  wire logic                data_keeper_active_o,
    input  wire logic                port_ready_o,
    input  wire logic                reg_select_pullup_o,
    input  wire logic                wide_data_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] up;
    logic       rd_any;
    logic       rd_on;
    logic       rd_w;
    logic       wide_seen;
    // cycles out of reset; straps are settled from the third edge on
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    // wide strap taken once on the first edge after release, later changes ignored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) wide_seen <= 1'b0;
        else if (up == 2'h0) wide_seen <= wide_mode_strap_i;
    end
    // a selected read strobe on an enabled, powered port
    assign rd_any = !host_ctl_i.data_strobe_n && host_ctl_i.read_not_write
                    && !host_ctl_i.port_select_n && output_off_n_i && !reg_select_pullup_o;
    // narrow reads use the byte lines, wide reads the word bus only
    assign rd_on = rd_any && !wide_seen;
    assign rd_w  = rd_any && wide_seen;
    property p_off; !output_off_n_i [*2] |-> &host_data_lines_oe_n_o; endproperty
    a_off: assert property (p_off) else $error("lines driven with output off");
    property p_rd; rd_on [*3] |-> ~|host_data_lines_oe_n_o; endproperty
    a_rd: assert property (p_rd) else $error("read data not driven");
    property p_wrd; rd_w [*3] |-> !wide_data_oe_n_o && &host_data_lines_oe_n_o; endproperty
    a_wrd: assert property (p_wrd) else $error("wide read not on word bus");
    property p_rel;
        $rose(host_ctl_i.data_strobe_n) && !gpio_mode_i |-> ##2 &host_data_lines_oe_n_o;
    endproperty
    a_rel: assert property (p_rel) else $error("lines held after strobe end");
    property p_busy;
        $rose(host_ctl_i.data_strobe_n) && !host_ctl_i.port_select_n && !reg_select_pullup_o
            |=> !port_ready_o [*2];
    endproperty
    a_busy: assert property (p_busy) else $error("ready not held low after strobe");
    property p_krst; disable iff (1'b0) rst_i |-> !data_keeper_active_o; endproperty
    a_krst: assert property (p_krst) else $error("keepers on in reset");
    property p_keep; $rose(data_keeper_enable_i) |-> ##[1:2] data_keeper_active_o; endproperty
    a_keep: assert property (p_keep) else $error("keeper bit not followed");
    property p_stab; up == 2'h3 |-> $stable(reg_select_pullup_o); endproperty
    a_stab: assert property (p_stab) else $error("strap effect changed after start");
    property p_strap; reg_select_pullup_o && !gpio_mode_i |-> &host_data_lines_oe_n_o; endproperty
    a_strap: assert property (p_strap) else $error("disabled port drives lines");
    c_rd: cover property (rd_on [*3]);
    c_keep: cover property ($rose(data_keeper_enable_i));
    c_off: cover property (reg_select_pullup_o);
    c_wrd: cover property (rd_w [*3]);
endmodule : host_port_chk
bind host_port_pin_interface host_port_chk i_chk (.clk_i, .rst_i, .output_off_n_i, .host_ctl_i,
    .data_keeper_enable_i, .gpio_mode_i, .wide_mode_strap_i, .host_data_lines_oe_n_o,
    .data_keeper_active_o, .port_ready_o, .reg_select_pullup_o, .wide_data_oe_n_o);
`default_nettype wire

// file: host_port_host.sv
// host-side partner: resolves the shared data wire seen by both ends
`timescale 1ns/100ps
`default_nettype none
module host_port_host (
    // clock
    input  wire logic       clk_i,
    // device and host drivers
    input  wire logic [7:0] dev_d_i,
    input  wire logic [7:0] dev_oe_n_i,
    input  wire logic       keep_on_i,
    input  wire logic [7:0] keep_lvl_i,
    input  wire logic       host_en_i,
    input  wire logic [7:0] host_d_i,
    // resolved wire
    output var  logic [7:0] line_o
);
    logic [7:0] drift = 8'h00;
    // undriven lines wander so a stale value never passes for a keeper
    always_ff @(posedge clk_i) drift <= ~drift;
    // per-bit resolution: device, then host, then keeper, else floating
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (!dev_oe_n_i[b]) line_o[b] = dev_d_i[b];
            else if (host_en_i) line_o[b] = host_d_i[b];
            else if (keep_on_i) line_o[b] = keep_lvl_i[b];
            else line_o[b] = drift[b];
        end
    end
endmodule : host_port_host
`default_nettype wire

// file: tb_host_port_pin_interface.sv
// testbench: host port pin block driven through host strobe tasks
`timescale 1ns/100ps
`default_nettype none
module tb_host_port_pin_interface;
    import host_port_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, en_s = 1'b1, off_n = 1'b1;
    logic        keep_en = 1'b0, gm = 1'b0, hen = 1'b0, kon, rdy, pu;
    logic        ws = 1'b0, woe, wo;
    logic [7:0]  hd = 8'h00, gout = 8'h00, gdir = 8'h00, line, ddo, doe, klv, rd, ro;
    logic [7:0]  gin;
    logic [15:0] ptr, ctr, wdo, wdi = 16'h0000;
    host_ctl_t   ctl = 7'h7f;
    int          n_fail = 0;
    int          checked = 0;
    always #25 clk_i = ~clk_i;
    host_port_pin_interface i_dut (.clk_i, .rst_i, .port_enable_strap_i(en_s),
        .wide_mode_strap_i(ws), .output_off_n_i(off_n), .host_ctl_i(ctl),
        .wide_data_i(wdi), .host_data_lines_i(line), .host_data_lines_o(ddo),
        .host_data_lines_oe_n_o(doe), .data_keeper_level_o(klv), .data_keeper_active_o(kon),
        .port_ready_o(rdy), .reg_select_pullup_o(pu), .wide_data_o(wdo), .wide_data_oe_n_o(woe),
        .data_keeper_enable_i(keep_en), .gpio_mode_i(gm), .gpio_out_i(gout),
        .gpio_dir_i(gdir), .gpio_in_o(gin), .address_pointer_reg_o(ptr), .control_reg_o(ctr));
    host_port_host i_host (.clk_i, .dev_d_i(ddo), .dev_oe_n_i(doe), .keep_on_i(kon),
        .keep_lvl_i(klv), .host_en_i(hen), .host_d_i(hd), .line_o(line));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one host strobe; select stays low over the whole access, ready gates the start
    task automatic xfer(input logic adr, rnw, bi, input logic [1:0] sel, input logic [7:0] d);
        int i;
        for (i = 0; i < 50; i++) begin
            @(negedge clk_i);
            if (rdy === 1'b1) break;
        end
        if (i == 50) begin
            chk(16'(rdy), 16'h0001);
            end_of_test;
        end
        @(posedge clk_i);
        hd <= d;
        hen <= !rnw;
        ctl <= '{1'b0, adr, !adr, rnw, bi, sel};
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rd = line;
        ro = doe;
        wo = woe;
        @(posedge clk_i);
        ctl.data_strobe_n <= 1'b1;
        ctl.address_strobe_n <= 1'b1;
        @(posedge clk_i);
        ctl.port_select_n <= 1'b1;
        hen <= 1'b0;
    endtask : xfer
    initial begin
        repeat (8) @(posedge clk_i);
        chk(16'({doe, kon, rdy, pu}), 16'h07f8);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk(16'({rdy, pu}), 16'h0002);
        $display("reset test done");
        xfer(1'b0, 1'b0, 1'b0, 2'h0, 8'h12);
        xfer(1'b0, 1'b0, 1'b1, 2'h0, 8'h34);
        repeat (2) @(negedge clk_i);
        chk(ctr, 16'h1234);
        xfer(1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
        chk(16'({ro, rd}), 16'h0012);
        xfer(1'b0, 1'b1, 1'b1, 2'h0, 8'h00);
        chk(16'({ro, rd}), 16'h0034);
        xfer(1'b1, 1'b0, 1'b0, 2'h2, 8'hab);
        xfer(1'b1, 1'b0, 1'b0, 2'h2, 8'h03);
        repeat (2) @(negedge clk_i);
        chk(ptr, 16'hab03);
        // data codes: auto-increment write, select-coded pointer load, data reads
        xfer(1'b0, 1'b0, 1'b0, 2'h1, 8'h11);
        xfer(1'b0, 1'b0, 1'b1, 2'h1, 8'h22);
        xfer(1'b0, 1'b0, 1'b0, 2'h2, 8'hab);
        xfer(1'b0, 1'b0, 1'b1, 2'h2, 8'h03);
        @(negedge clk_i);
        chk(ptr, 16'hab03);
        xfer(1'b0, 1'b1, 1'b0, 2'h3, 8'h00);
        chk(16'({ro, rd}), 16'h0011);
        xfer(1'b0, 1'b1, 1'b1, 2'h1, 8'h00);
        chk(16'({ro, rd}), 16'h0022);
        @(negedge clk_i);
        chk(ptr, 16'hab04);
        $display("register test done");
        @(posedge clk_i);
        off_n <= 1'b0;
        xfer(1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
        chk(16'(ro), 16'h00ff);
        off_n <= 1'b1;
        $display("output off test done");
        @(posedge clk_i);
        keep_en <= 1'b1;
        hd <= 8'h5a;
        hen <= 1'b1;
        repeat (3) @(posedge clk_i);
        hen <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk(16'({kon, line}), 16'h015a);
        $display("keeper test done");
        @(posedge clk_i);
        gm <= 1'b1;
        gdir <= 8'hff;
        gout <= 8'ha5;
        repeat (3) @(negedge clk_i);
        chk(16'(line), 16'h00a5);
        chk(16'(gin), 16'h00a5);
        $display("general io test done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        en_s <= 1'b0;
        gm <= 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ctl <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0};
        en_s <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk(16'({pu, rdy, doe}), 16'h02ff);
        $display("strap off test done");
        // wide mode: select and byte pins ignored, whole word on the word bus
        @(posedge clk_i);
        rst_i <= 1'b1;
        ws <= 1'b1;
        wdi <= 16'hbe5a;
        ctl <= 7'h7f;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        xfer(1'b0, 1'b0, 1'b0, 2'h0, 8'h00);
        xfer(1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
        chk(16'({wo, ro}), 16'h00ff);
        @(negedge clk_i);
        chk(wdo, 16'hbe5a);
        chk(ctr, 16'h0000);
        $display("wide mode test done");
        end_of_test;
    end
endmodule : tb_host_port_pin_interface
`default_nettype wire
